/* bench/sbs_engine_model.sv */
// Behavioural shift engine that feeds finished transfers into the block.
// Assumes the bench starts one transfer at a time and holds its fields.
`timescale 1ns/1ps
module sbs_engine_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Commands from the bench
  input wire logic start,
  input wire logic [15:0] word,
  input wire logic [1:0] sel,
  input wire logic [4:0] len,
  input wire logic [3:0] wait_cyc,
  // Engine side of the block
  input wire logic tx_pending_flag,
  output logic xfer_done,
  output logic [15:0] xfer_data,
  output logic [1:0] xfer_select,
  output logic [4:0] xfer_len,
  output logic tx_take
);
  logic [3:0] cnt_ff;
  logic busy_ff;
  // Outside the done pulse the data lines toggle so stale values never look valid
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      {cnt_ff, busy_ff, xfer_done, tx_take} <= 7'h00;
      {xfer_data, xfer_select, xfer_len} <= 23'h000000;
    end
    else if (start)
    begin
      busy_ff <= 1'b1;
      cnt_ff <= wait_cyc;
    end
    else if (busy_ff && cnt_ff == 4'h0)
    begin
      busy_ff <= 1'b0;
      xfer_done <= 1'b1;
      {xfer_data, xfer_select, xfer_len} <= {word, sel, len};
      tx_take <= tx_pending_flag; // A pending word is taken as the frame ends
    end
    else
    begin
      cnt_ff <= cnt_ff - 4'h1;
      {xfer_done, tx_take} <= 2'b00;
      {xfer_data, xfer_select} <= ~{xfer_data, xfer_select};
    end
  end
endmodule // sbs_engine_model

/* bench/sbs_top_bench.sv */
// Self-checking bench for the receive buffer and transmit status block.
// Assumes the engine model file is compiled first.
`timescale 1ns/1ps
module sbs_top_bench;
  import sbs_pkg::*;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, start, slverr;
  logic xfer_done, tx_take, tx_pending_flag, rx_irq_flag, overrun_irq_flag;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  logic [15:0] word, xfer_data, tx_data, e_data;
  logic [1:0] sel, xfer_select, tx_select, e_sel;
  logic [4:0] len, xfer_len;
  logic [3:0] wait_cyc;
  logic e_empty, e_ovr, e_tx, e_rxirq, e_ovrirq;
  int miscompares, checks, cycles;
  sbs_top sbs_top_inst (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .xfer_done(xfer_done), .xfer_data(xfer_data), .xfer_select(xfer_select),
    .xfer_len(xfer_len), .tx_take(tx_take), .tx_pending_flag(tx_pending_flag), .tx_data(tx_data),
    .tx_select(tx_select), .rx_irq_flag(rx_irq_flag), .overrun_irq_flag(overrun_irq_flag));
  sbs_engine_model sbs_engine_model_inst (.pclk(pclk), .presetn(presetn), .start(start),
    .word(word), .sel(sel), .len(len), .wait_cyc(wait_cyc), .tx_pending_flag(tx_pending_flag),
    .xfer_done(xfer_done), .xfer_data(xfer_data), .xfer_select(xfer_select),
    .xfer_len(xfer_len), .tx_take(tx_take));
  // Clock and hang guard; the ceiling is far above the few hundred cycles needed
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      miscompares++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value %0s expected %h seen %h", what, exp, got);
    end
  endtask
  // One APB transfer; the request holds until pready is seen, then one idle cycle
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      @(posedge pclk);
    end
    rd = prdata;
    slverr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Reads the buffer, compares every field, then applies the read side effects
  task automatic read_buf();
    apb(1'b0, SBS_ADDR_RXBUF, 32'h0);
    chk("buffer", {e_empty, e_ovr, e_tx, 11'h000, e_sel, e_data}, rd);
    {e_empty, e_ovr, e_rxirq, e_ovrirq} = 4'b1000;
    chk("irq flags", {30'h0, e_ovrirq, e_rxirq}, {30'h0, overrun_irq_flag, rx_irq_flag});
    apb(1'b0, SBS_ADDR_FLAG, 32'h0);
    chk("flag reg", 32'h0, rd);
  endtask
  // Lets the engine finish one word and folds it into the expected state
  task automatic xfer(input logic [4:0] l);
    {word, sel, len, wait_cyc} = {seed[15:0], seed[17:16], l, seed[23:20]};
    start <= 1'b1;
    @(posedge pclk);
    start <= 1'b0;
    while (xfer_done !== 1'b1)
    begin
      @(posedge pclk);
    end
    @(posedge pclk);
    e_ovr = e_ovr | ~e_empty;
    e_ovrirq = e_ovrirq | ~e_empty;
    e_data = (l == 5'h00) ? word : word & ~(16'hffff << l);
    {e_empty, e_sel, e_rxirq, e_tx} = {1'b0, sel, 1'b1, 1'b0};
    chk("irq after done", {e_ovrirq, e_rxirq}, {overrun_irq_flag, rx_irq_flag});
  endtask
  initial
  begin
    logic [4:0] lens [4] = '{5'h00, 5'h01, 5'h08, 5'h0f};
    seed = 32'h289d;
    {presetn, ce, psel, penable, pwrite, paddr, pwdata, start, word, sel, len} = '0;
    wait_cyc = 4'h0;
    {e_empty, e_ovr, e_tx, e_rxirq, e_ovrirq, e_data, e_sel} = {5'b10000, 18'h0};
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    ce <= 1'b1;
    @(posedge pclk);
    read_buf();
    apb(1'b1, SBS_ADDR_RXBUF, 32'hffff_ffff);
    read_buf();
    apb(1'b0, 12'h00c, 32'h0);
    chk("slave error", 32'h1, {31'h0, slverr});
    $display("test reset and refusals done");
    // Two full-length words with no read between force an overrun
    xfer(5'h00);
    seed = $random(seed);
    xfer(5'h00);
    read_buf();
    // A word finished while frozen must leave every flag and field alone
    ce <= 1'b0;
    start <= 1'b1;
    @(posedge pclk);
    start <= 1'b0;
    while (xfer_done !== 1'b1)
    begin
      @(posedge pclk);
    end
    @(posedge pclk);
    ce <= 1'b1;
    read_buf();
    $display("test overrun and freeze done");
    for (int i = 0; i < 8; i++)
    begin
      seed = $random(seed);
      if (seed[24])
      begin
        apb(1'b1, SBS_ADDR_SHIFT, seed);
        e_tx = 1'b1;
        chk("tx out", {14'h0, seed[17:0]}, {14'h0, tx_select, tx_data});
        chk("tx flag", 32'h1, {31'h0, tx_pending_flag});
        apb(1'b0, SBS_ADDR_SHIFT, 32'h0);
        chk("shift readback", {14'h0, seed[17:0]}, rd);
      end
      xfer(lens[i % 4]);
      if (seed[25])
        xfer(lens[(i + 1) % 4]);
      if (seed[26])
      begin
        // Write-one-to-clear on the irq flags, overrun only when its bit is set
        apb(1'b1, SBS_ADDR_FLAG, {30'h0, seed[27], 1'b1});
        e_rxirq = 1'b0;
        e_ovrirq = e_ovrirq & ~seed[27];
        chk("irq after clear", {30'h0, e_ovrirq, e_rxirq},
          {30'h0, overrun_irq_flag, rx_irq_flag});
      end
      read_buf();
    end
    $display("test transfers done");
    summarize();
  end
endmodule // sbs_top_bench

/* rtl/sbs_flag.sv */
// One status flag with a hardware event and a clearing event.
// Assumes both events are single-cycle pulses on pclk.
`timescale 1ns/1ps
module sbs_flag #(
  parameter logic RST_VAL = 1'b0
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // Events
  input wire logic set_ev,
  input wire logic clr_ev,
  // Flag level
  output logic q
);
  typedef struct packed {
    logic q;
  } sbs_flag_st_t;

  sbs_flag_st_t st_ff;
  sbs_flag_st_t nxt_st;

  // The set wins so an event landing on the clear cycle is never lost
  always_comb
  begin
    nxt_st = st_ff;
    if (set_ev)
    begin
      nxt_st.q = 1'b1;
    end
    else if (clr_ev)
    begin
      nxt_st.q = 1'b0;
    end
  end

  // State register, frozen while ce is low
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_ff.q <= RST_VAL;
    end
    else if (ce)
    begin
      st_ff <= nxt_st;
    end
  end

  assign q = st_ff.q;
endmodule // sbs_flag

/* rtl/sbs_pkg.sv */
// Constants for the receive-buffer and transmit-status block of a serial port.
// Assumes an APB master on pclk and a shift engine that pulses its events on pclk.
// What this block does
// [R1] Buffer read clears overrun and receive irq flags
// [R2] Buffer read sets the receive-empty bit
// [R3] Word written back clears the receive-empty bit
// [R4] Host writes to the buffer address never change status bits
// [R5] Reading the buffer clears the overrun bit
// [R6] Write-back while not empty sets overrun
// [R7] Shift data write sets transmit-pending bit
// [R8] Engine taking the word clears transmit-pending
// [R9] Received word stored right-justified, MSB first
// [R10] Write-back copies select number into buffer
// [R11] Overrun word replaces previous buffer contents
package sbs_pkg;
  // Register byte offsets on the APB
  localparam logic [11:0] SBS_ADDR_RXBUF = 12'h000;
  localparam logic [11:0] SBS_ADDR_SHIFT = 12'h004;
  localparam logic [11:0] SBS_ADDR_FLAG = 12'h008;
  // Receive buffer register fields
  localparam int SBS_RX_EMPTY_FLAG_BIT = 31;
  localparam int SBS_RX_OVERRUN_FLAG_BIT = 30;
  localparam int SBS_TXPEND_BIT = 29;
  localparam int SBS_LCS_LO = 16;
  localparam int SBS_DATA_W = 16;
  localparam int SBS_SEL_W = 2;
  localparam int SBS_LEN_W = 5;
  // Interrupt flag register fields
  localparam int SBS_RXIRQ_BIT = 0;
  localparam int SBS_OVRIRQ_BIT = 1;
  // Reset values
  localparam logic SBS_RX_EMPTY_FLAG_RST = 1'b1;
  localparam logic SBS_FLAG_RST = 1'b0;
  localparam logic [15:0] SBS_DATA_RST = 16'h0000;
  localparam logic [1:0] SBS_SEL_RST = 2'h0;
  localparam logic [31:0] SBS_RDATA_RST = 32'h0000_0000;
endpackage

/* rtl/sbs_top.sv */
// APB register slave for the receive buffer, shift data and irq flags.
// Assumes the shift engine pulses xfer_done and tx_take for one pclk cycle.
//
// Chosen here: the address map and the APB slave port.
`timescale 1ns/1ps
module sbs_top (
  // Clock, reset, freeze
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Receive side of the shift engine
  input wire logic xfer_done,
  input wire logic [sbs_pkg::SBS_DATA_W-1:0] xfer_data,
  input wire logic [sbs_pkg::SBS_SEL_W-1:0] xfer_select,
  input wire logic [sbs_pkg::SBS_LEN_W-1:0] xfer_len,
  // Transmit side of the shift engine
  input wire logic tx_take,
  output logic tx_pending_flag,
  output logic [sbs_pkg::SBS_DATA_W-1:0] tx_data,
  output logic [sbs_pkg::SBS_SEL_W-1:0] tx_select,
  // Flag levels for the interrupt logic outside
  output logic rx_irq_flag,
  output logic overrun_irq_flag
);
  import sbs_pkg::*;

  typedef struct packed {
    logic ack;
    logic slverr;
    logic [31:0] rdata;
    logic [SBS_DATA_W-1:0] rx_data;
    logic [SBS_SEL_W-1:0] last_select_number;
    logic [SBS_DATA_W-1:0] tx_data;
    logic [SBS_SEL_W-1:0] select_number;
  } sbs_top_st_t;

  sbs_top_st_t st_ff;
  sbs_top_st_t nxt_st;
  logic rx_empty_flag;
  logic rx_overrun_flag;
  logic hit_rxbuf;
  logic hit_shift;
  logic hit_flag;
  logic mapped;
  logic rd_take;
  logic wr_take;
  logic wr_shift;
  logic wr_flag;
  logic overrun_ev;

  // Decode; reads act on the first access cycle so data and side effects agree
  assign hit_rxbuf = (paddr == SBS_ADDR_RXBUF);
  assign hit_shift = (paddr == SBS_ADDR_SHIFT);
  assign hit_flag = (paddr == SBS_ADDR_FLAG);
  assign mapped = hit_rxbuf || hit_shift || hit_flag;
  assign rd_take = psel && penable && !st_ff.ack && !pwrite && hit_rxbuf;
  assign wr_take = psel && penable && st_ff.ack && pwrite;
  assign wr_shift = wr_take && hit_shift;
  assign wr_flag = wr_take && hit_flag;
  assign overrun_ev = xfer_done && !rx_empty_flag; // see [R6]

  // Status flags, set-over-clear except empty, where xfer_done beats the read set
  sbs_flag #(.RST_VAL(SBS_RX_EMPTY_FLAG_RST)) u_rx_empty (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .set_ev(rd_take && !xfer_done), // see [R2]
    .clr_ev(xfer_done), // see [R3]
    .q(rx_empty_flag)
  );

  sbs_flag #(.RST_VAL(SBS_FLAG_RST)) u_rx_ovr (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .set_ev(overrun_ev), // see [R6]
    .clr_ev(rd_take), // see [R5]
    .q(rx_overrun_flag)
  );

  sbs_flag #(.RST_VAL(SBS_FLAG_RST)) u_tx_pend (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .set_ev(wr_shift), // see [R7]
    .clr_ev(tx_take), // see [R8]
    .q(tx_pending_flag)
  );

  // Irq flags: read of the buffer or write-one clears, new events win
  sbs_flag #(.RST_VAL(SBS_FLAG_RST)) u_rx_irq (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .set_ev(xfer_done),
    .clr_ev(rd_take || (wr_flag && pwdata[SBS_RXIRQ_BIT])), // see [R1]
    .q(rx_irq_flag)
  );

  sbs_flag #(.RST_VAL(SBS_FLAG_RST)) u_ovr_irq (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .set_ev(overrun_ev),
    .clr_ev(rd_take || (wr_flag && pwdata[SBS_OVRIRQ_BIT])), // see [R1]
    .q(overrun_irq_flag)
  );

  // Bus answer, read mux and data write-back
  always_comb
  begin
    logic [SBS_DATA_W-1:0] len_mask;
    len_mask = '0;
    nxt_st = st_ff;
    for (int i = 0; i < SBS_DATA_W; i++)
    begin
      len_mask[i] = (xfer_len == '0) || (i < int'(xfer_len)); // see [R9]
    end
    // One wait state, then pready for exactly one cycle
    nxt_st.ack = psel && penable && !st_ff.ack;
    if (psel && penable && !st_ff.ack)
    begin
      nxt_st.slverr = !mapped;
      nxt_st.rdata = SBS_RDATA_RST;
      if (!pwrite && hit_rxbuf)
      begin
        nxt_st.rdata[SBS_RX_EMPTY_FLAG_BIT] = rx_empty_flag;
        nxt_st.rdata[SBS_RX_OVERRUN_FLAG_BIT] = rx_overrun_flag;
        nxt_st.rdata[SBS_TXPEND_BIT] = tx_pending_flag;
        nxt_st.rdata[SBS_LCS_LO +: SBS_SEL_W] = st_ff.last_select_number;
        nxt_st.rdata[SBS_DATA_W-1:0] = st_ff.rx_data;
      end
      else if (!pwrite && hit_shift)
      begin
        nxt_st.rdata[SBS_LCS_LO +: SBS_SEL_W] = st_ff.select_number;
        nxt_st.rdata[SBS_DATA_W-1:0] = st_ff.tx_data;
      end
      else if (!pwrite && hit_flag)
      begin
        nxt_st.rdata[SBS_RXIRQ_BIT] = rx_irq_flag;
        nxt_st.rdata[SBS_OVRIRQ_BIT] = overrun_irq_flag;
      end
    end
    // Newest word always overwrites, even on overrun
    if (xfer_done)
    begin
      nxt_st.rx_data = xfer_data & len_mask; // see [R9] see [R11]
      nxt_st.last_select_number = xfer_select; // see [R10]
    end
    // Writes to the buffer address are dropped; status bits are hardware-owned, see [R4]
    if (wr_shift)
    begin
      nxt_st.tx_data = pwdata[SBS_DATA_W-1:0];
      nxt_st.select_number = pwdata[SBS_LCS_LO +: SBS_SEL_W];
    end
  end

  // Registered state, frozen while ce is low
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_ff.ack <= 1'b0;
      st_ff.slverr <= 1'b0;
      st_ff.rdata <= SBS_RDATA_RST;
      st_ff.rx_data <= SBS_DATA_RST;
      st_ff.last_select_number <= SBS_SEL_RST;
      st_ff.tx_data <= SBS_DATA_RST;
      st_ff.select_number <= SBS_SEL_RST;
    end
    else if (ce)
    begin
      st_ff <= nxt_st;
    end
  end

  assign pready = st_ff.ack;
  assign pslverr = st_ff.ack && st_ff.slverr;
  assign prdata = st_ff.rdata;
  assign tx_data = st_ff.tx_data;
  assign tx_select = st_ff.select_number;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_read_clears_irq;
    rd_take && ce && !xfer_done |=> !rx_irq_flag && !overrun_irq_flag;
  endproperty
  a_read_clears_irq: assert property (p_read_clears_irq) else $error("irq flags not cleared"); // see [R1]

  property p_read_sets_empty;
    rd_take && ce && !xfer_done |=> rx_empty_flag && prdata[SBS_RX_EMPTY_FLAG_BIT] == $past(rx_empty_flag);
  endproperty
  a_read_sets_empty: assert property (p_read_sets_empty) else $error("empty not set on read"); // see [R2]

  property p_done_clears_empty;
    xfer_done && ce |=> !rx_empty_flag;
  endproperty
  a_done_clears_empty: assert property (p_done_clears_empty) else $error("empty not cleared"); // see [R3]

  property p_write_no_status;
    wr_take && hit_rxbuf && ce && !xfer_done && !tx_take |=> $stable(rx_empty_flag) && $stable(tx_pending_flag);
  endproperty
  a_write_no_status: assert property (p_write_no_status) else $error("status changed by write"); // see [R4]

  property p_read_clears_ovr;
    rd_take && ce && !xfer_done |=> !rx_overrun_flag;
  endproperty
  a_read_clears_ovr: assert property (p_read_clears_ovr) else $error("overrun not cleared"); // see [R5]

  property p_overrun_set;
    xfer_done && ce && !rx_empty_flag |=> rx_overrun_flag && overrun_irq_flag;
  endproperty
  a_overrun_set: assert property (p_overrun_set) else $error("overrun not set"); // see [R6]

  property p_tx_set;
    wr_shift && ce |=> tx_pending_flag && tx_data == $past(pwdata[15:0]);
  endproperty
  a_tx_set: assert property (p_tx_set) else $error("pending not set"); // see [R7]

  property p_tx_clear;
    tx_take && ce && !wr_shift |=> !tx_pending_flag;
  endproperty
  a_tx_clear: assert property (p_tx_clear) else $error("pending not cleared"); // see [R8]

  property p_right_just;
    xfer_done && ce && xfer_len == 5'h08 |=> st_ff.rx_data == ($past(xfer_data) & 16'h00ff);
  endproperty
  a_right_just: assert property (p_right_just) else $error("data not right-justified"); // see [R9]

  property p_last_sel;
    xfer_done && ce |=> st_ff.last_select_number == $past(xfer_select);
  endproperty
  a_last_sel: assert property (p_last_sel) else $error("select number not copied"); // see [R10]

  property p_ovr_replace;
    xfer_done && ce && !rx_empty_flag && xfer_len == 5'h00 |=> st_ff.rx_data == $past(xfer_data);
  endproperty
  a_ovr_replace: assert property (p_ovr_replace) else $error("overrun word not kept"); // see [R11]

  property p_ready_one;
    psel && penable && !pready && ce ##1 ce |=> !pready;
  endproperty
  a_ready_one: assert property (p_ready_one) else $error("pready longer than one cycle");

  c_read: cover property (rd_take && ce ##1 pready);
  c_overrun: cover property (overrun_ev && ce);
  c_tx: cover property (wr_shift ##[1:20] tx_take);
  c_race: cover property (rd_take && xfer_done && ce);
endmodule // sbs_top
